/* rtl/wdps_top.sv */
/*
  Postscaled watchdog top: APB register slave, enable logic, reset
  request and interrupt. Assumes APB master on pclk; config and
  oscillator-fail inputs come from outside and are synchronised.
*/
// The register offsets and register access over APB are this design's own decisions.
`default_nettype none
module wdps_top
  import wdps_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WDPS_BASE_CYCLES,
  parameter logic [7:0] PART_ID = WDPS_PART_ID_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and core events
  input wire logic config_watchdog_enable,
  input wire logic [3:0] period_select_field,
  input wire logic clear_watchdog_instruction,
  input wire logic sleep_instruction,
  input wire logic osc_fail,
  // Outputs
  output logic device_reset,
  output logic internal_rc_clock_enable,
  output logic irq
);
  // ----------------------------------------------------------------
  // Synchronisers and counter chain
  // ----------------------------------------------------------------
  logic cfg_en_s;
  logic osc_fail_s;

  wdps_sync u_sync_cfg (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .d(config_watchdog_enable), .q(cfg_en_s)
  );
  wdps_sync u_sync_osc (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .d(osc_fail), .q(osc_fail_s)
  );

  wdps_evt_if evt ();

  wdps_counter #(.BASE_CYCLES(BASE_CYCLES)) u_cnt (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .evt(evt)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic swen;
    logic timeout;
    logic osc_fail_d;
    logic rst_pulse;
    logic [WDPS_IRQ_BITS-1:0] irq_stat;
    logic [WDPS_IRQ_BITS-1:0] irq_mask;
    logic [31:0] rdata;
    logic [3:0] sel;
  } wdps_top_t;

  wdps_top_t st_ff, nxt_st;
  logic run;
  logic clr_evt;
  logic osc_edge;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [WDPS_IRQ_BITS-1:0] evt_set;
  logic [31:0] rd_val;

  assign run = cfg_en_s | st_ff.swen;
  assign osc_edge = osc_fail_s & ~st_ff.osc_fail_d;
  assign clr_evt = clear_watchdog_instruction | sleep_instruction | osc_edge;

  // The period select is registered so a mid-count change takes a clean edge.
  assign evt.run = run;
  assign evt.clear = clr_evt;
  assign evt.sel = st_ff.sel;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == WDPS_OFF_CONTROL) || (paddr == WDPS_OFF_STATUS)
    || (paddr == WDPS_OFF_IRQ_STAT) || (paddr == WDPS_OFF_IRQ_MASK)
    || (paddr == WDPS_OFF_PART_ID);

  // Read mux; reserved bits read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      WDPS_OFF_CONTROL: rd_val[WDPS_CTL_SWEN_BIT] = st_ff.swen;
      WDPS_OFF_STATUS: begin
        rd_val[WDPS_ST_RUN_BIT] = run;
        rd_val[WDPS_ST_TIMEOUT_BIT] = st_ff.timeout;
      end
      WDPS_OFF_IRQ_STAT: rd_val[WDPS_IRQ_BITS-1:0] = st_ff.irq_stat;
      WDPS_OFF_IRQ_MASK: rd_val[WDPS_IRQ_BITS-1:0] = st_ff.irq_mask;
      WDPS_OFF_PART_ID: rd_val[7:0] = PART_ID;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Interrupt events.
  always_comb begin
    evt_set = '0;
    evt_set[WDPS_IRQ_EXPIRE_BIT] = evt.expire;
    evt_set[WDPS_IRQ_CLEAR_BIT] = clk_en & clr_evt & run;
    evt_set[WDPS_IRQ_OSCFAIL_BIT] = clk_en & osc_edge;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.rst_pulse = 1'b0;
      nxt_st.osc_fail_d = osc_fail_s;
      nxt_st.sel = period_select_field;
      if (rd_en) begin
        nxt_st.rdata = rd_val;
      end
      // A clear instruction drops the timeout indication.
      if (clear_watchdog_instruction) begin
        nxt_st.timeout = 1'b0;
      end
      if (evt.expire) begin
        nxt_st.rst_pulse = 1'b1;
        nxt_st.timeout = 1'b1;
      end
      if (wr_en && addr_ok) begin
        unique case (paddr)
          WDPS_OFF_CONTROL: nxt_st.swen = pwdata[WDPS_CTL_SWEN_BIT];
          WDPS_OFF_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat
            & ~pwdata[WDPS_IRQ_BITS-1:0];
          WDPS_OFF_IRQ_MASK: nxt_st.irq_mask = pwdata[WDPS_IRQ_BITS-1:0];
          default: nxt_st.irq_mask = st_ff.irq_mask;
        endcase
      end
      // Set wins over a same-cycle write-one clear.
      nxt_st.irq_stat = nxt_st.irq_stat | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.swen <= WDPS_SWEN_RST;
      st_ff.irq_stat <= WDPS_IRQ_RST;
      st_ff.irq_mask <= WDPS_IRQ_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No wait states: data sampled in setup, answered in access.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = st_ff.rdata;
  assign device_reset = st_ff.rst_pulse;
  assign internal_rc_clock_enable = run;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
endmodule // wdps_top
`default_nettype wire

/* rtl/wdps_pkg.sv */
/*
  Package for the postscaled watchdog: register map, field positions,
  reset values and timing counts.
  Assumes a 10 MHz pclk and an APB register bus with 32-bit data.
*/
`default_nettype none
package wdps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned WDPS_CLK_HZ = 10_000_000;
  localparam int unsigned WDPS_BASE_PERIOD_US = 4_000;
  localparam int unsigned WDPS_BASE_CYCLES =
    (WDPS_BASE_PERIOD_US / 1_000) * (WDPS_CLK_HZ / 1_000);
  localparam int unsigned WDPS_POST_BITS = 16;
  localparam int unsigned WDPS_SEL_BITS = 4;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] WDPS_OFF_CONTROL = 12'h000;
  localparam logic [11:0] WDPS_OFF_STATUS = 12'h004;
  localparam logic [11:0] WDPS_OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] WDPS_OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] WDPS_OFF_PART_ID = 12'h010;

  // Field positions.
  localparam int unsigned WDPS_CTL_SWEN_BIT = 0;
  localparam int unsigned WDPS_ST_RUN_BIT = 0;
  localparam int unsigned WDPS_ST_TIMEOUT_BIT = 1;
  localparam int unsigned WDPS_IRQ_EXPIRE_BIT = 0;
  localparam int unsigned WDPS_IRQ_CLEAR_BIT = 1;
  localparam int unsigned WDPS_IRQ_OSCFAIL_BIT = 2;
  localparam int unsigned WDPS_IRQ_BITS = 3;

  // Reset values.
  localparam logic WDPS_SWEN_RST = 1'b0;
  localparam logic [WDPS_IRQ_BITS-1:0] WDPS_IRQ_RST = 3'h0;

  // Arbitrary neutral identity value.
  localparam logic [7:0] WDPS_PART_ID_DEFAULT = 8'h5A;

endpackage
`default_nettype wire

/* rtl/wdps_evt_if.sv */
/*
  Interface carrying watchdog counter events between the core of the
  watchdog and its counter chain. Assumes a single clock domain.
*/
`default_nettype none
interface wdps_evt_if;
  logic run;
  logic clear;
  logic [3:0] sel;
  logic expire;

  modport ctl (output run, output clear, output sel, input expire);
  modport cnt (input run, input clear, input sel, output expire);
endinterface
`default_nettype wire

/* rtl/wdps_sync.sv */
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes pclk and an active-low asynchronous reset.
*/
`default_nettype none
module wdps_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Level
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } wdps_sync_t;

  wdps_sync_t st_ff, nxt_st;

  // The first stage feeds only the second.
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule // wdps_sync
`default_nettype wire

/* rtl/wdps_counter.sv */
/*
  Base counter and 16-bit postscaler of the watchdog, with tap select.
  Assumes pclk as the internal RC clock stand-in and synchronous events.
*/
`default_nettype none
module wdps_counter
  import wdps_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WDPS_BASE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Event link
  wdps_evt_if.cnt evt
);
  localparam int unsigned BW = $clog2(BASE_CYCLES + 1);

  // A zero base count would wrap the tick compare; refuse it at elaboration.
  if (BASE_CYCLES < 1) begin : g_bad_base
    $error("BASE_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [BW-1:0] base;
    logic [WDPS_POST_BITS-1:0] post;
    logic expire;
  } wdps_cnt_t;

  wdps_cnt_t st_ff, nxt_st;
  logic base_tick;
  logic [WDPS_POST_BITS:0] post_limit;

  assign base_tick = (st_ff.base == BW'(BASE_CYCLES - 1));
  assign post_limit = (WDPS_POST_BITS + 1)'(1) << evt.sel;

  // Counting, clearing and expiry detection.
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      // The expiry strobe is frozen too, so a paused clock cannot lose it.
      nxt_st.expire = 1'b0;
      if (!evt.run || evt.clear) begin
        nxt_st.base = '0;
        nxt_st.post = '0;
      end else if (base_tick) begin
        nxt_st.base = '0;
        if ({1'b0, st_ff.post} == post_limit - 1'b1) begin
          nxt_st.post = '0;
          nxt_st.expire = 1'b1;
        end else begin
          nxt_st.post = st_ff.post + 1'b1;
        end
      end else begin
        nxt_st.base = st_ff.base + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign evt.expire = st_ff.expire;
endmodule // wdps_counter
`default_nettype wire

/* test/wdps_checker.sv */
/* Port checker for wdps_top, bound at the foot of this file.
   Assumes one clock domain on pclk and an active-low presetn. */
`default_nettype none
module wdps_checker #(
  parameter int unsigned BASE_CYCLES = 4
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // Events and outputs
  input wire logic config_watchdog_enable,
  input wire logic clear_watchdog_instruction,
  input wire logic sleep_instruction,
  input wire logic device_reset,
  input wire logic internal_rc_clock_enable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic kick;
  logic [31:0] age_ff;
  logic [31:0] nxt_age;
  assign kick = clear_watchdog_instruction || sleep_instruction;
  // Cycles since the counts were zeroed; oscillator clears only make it larger.
  always_comb begin
    nxt_age = (kick || !internal_rc_clock_enable) ? 32'h0 : age_ff + 32'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_ff <= 32'h0;
    end else begin
      age_ff <= nxt_age;
    end
  end
  a_err_decode: assert property (pslverr == (psel && penable &&
    !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010})))
    else $error("bus error flag does not match the address map");
  a_reset_pulse: assert property (device_reset |=> !device_reset)
    else $error("device reset wider than one cycle");
  // The pulse trails the expiry strobe by one register, so look two cycles back.
  a_reset_running: assert property (device_reset |->
    $past(internal_rc_clock_enable, 2))
    else $error("device reset while the watchdog is stopped");
  a_reset_base_time: assert property (device_reset |->
    $past(age_ff, 2) >= BASE_CYCLES - 1)
    else $error("device reset before one base period");
  a_kick_holds: assert property (kick |-> ##2 !device_reset ##1 !device_reset)
    else $error("device reset soon after a clear");
  a_cfg_forces_on: assert property (config_watchdog_enable [*3] |->
    internal_rc_clock_enable)
    else $error("configuration enable does not start the watchdog");
  a_rc_cause: assert property ($rose(internal_rc_clock_enable) |->
    $past(psel && penable && pwrite) || $past(config_watchdog_enable, 2))
    else $error("watchdog started without a cause");
  a_irq_by_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("interrupt dropped without a register write");
endmodule // wdps_checker
bind wdps_top wdps_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pslverr(pslverr), .config_watchdog_enable(config_watchdog_enable),
  .clear_watchdog_instruction(clear_watchdog_instruction),
  .sleep_instruction(sleep_instruction), .device_reset(device_reset),
  .internal_rc_clock_enable(internal_rc_clock_enable), .irq(irq));
`default_nettype wire

/* test/wdps_core_model.sv */
/* Model of the core that services the watchdog by clear or sleep.
   Assumes pclk and an active-low presetn from the bench. */
`default_nettype none
module wdps_core_model #(
  parameter int unsigned GAP = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Service requests
  input wire logic kick_en,
  input wire logic kick_sleep,
  // Instruction pulses
  output logic clear_watchdog_instruction,
  output logic sleep_instruction
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gap_ff;
  logic hit;
  assign hit = kick_en && gap_ff == 8'(GAP - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 8'h00;
      clear_watchdog_instruction <= 1'b0;
      sleep_instruction <= 1'b0;
    end else begin
      gap_ff <= (!kick_en || hit) ? 8'h00 : gap_ff + 8'h01;
      clear_watchdog_instruction <= hit && !kick_sleep;
      sleep_instruction <= hit && kick_sleep;
    end
  end
endmodule // wdps_core_model
`default_nettype wire

/* test/wdps_top_test.sv */
/* Bench for wdps_top: register access over APB and timeout scenarios.
   Assumes the checker bind and the core model are compiled first. */
`default_nettype none
module wdps_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, cfg, osc, kick, ksl, rst, rc, irq, rdy, err, clr, slp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] sel;
  int err_total = 0;
  int checks_done = 0;
  int n;
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
  always #50 pclk = ~pclk;
  // Part id value is arbitrary.
  wdps_top #(.BASE_CYCLES(BASE), .PART_ID(8'hC3)) DUT (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(err),
    .config_watchdog_enable(cfg), .period_select_field(sel),
    .clear_watchdog_instruction(clr), .sleep_instruction(slp), .osc_fail(osc),
    .device_reset(rst), .internal_rc_clock_enable(rc), .irq(irq));
  wdps_core_model #(.GAP(3)) core (.pclk(pclk), .presetn(presetn), .kick_en(kick),
    .kick_sleep(ksl), .clear_watchdog_instruction(clr), .sleep_instruction(slp));
  // One transfer; on a read d is the expected data. Idles a cycle first.
  // Only the watchdog process below may end a wait for the slave.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rdy !== 1'b1);
    if (!w) `CHK(prdata, d)
    `CHK(err, e)
    {psel, penable} <= 2'h0;
  endtask
  task automatic wait_rst(input int lim);
    n = 0;
    while (rst !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cfg, osc, kick, ksl, sel} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'h0, 12'h000, 32'h0, 1'h0);
    apb(1'h1, 12'h000, 32'hFF, 1'h0);
    apb(1'h0, 12'h000, 32'h1, 1'h0);
    apb(1'h1, 12'h000, 32'h0, 1'h0);
    apb(1'h1, 12'h010, 32'h0, 1'h0);
    apb(1'h0, 12'h010, 32'hC3, 1'h0);
    apb(1'h1, 12'h024, 32'h1, 1'h1);
    apb(1'h0, 12'h024, 32'h0, 1'h1);
    apb(1'h1, 12'h00C, 32'h1, 1'h0);
    $display("register test done");
    // Disabling between runs zeroes the counts, so each run starts clean.
    for (int s = 0; s < 4; s++) begin
      sel <= 4'(s);
      apb(1'h1, 12'h000, 32'h1, 1'h0);
      wait_rst(400);
      // Period, one register for the pulse and one edge for the bench to see it.
      `CHK(n, (BASE << s) + 2)
      apb(1'h1, 12'h000, 32'h0, 1'h0);
    end
    apb(1'h0, 12'h004, 32'h2, 1'h0);
    `CHK(irq, 1'b1)
    apb(1'h1, 12'h00C, 32'h0, 1'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'h1, 12'h00C, 32'h1, 1'h0);
    apb(1'h1, 12'h008, 32'h1, 1'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("period test done");
    for (int k = 0; k < 2; k++) begin
      {kick, ksl} <= {1'b1, 1'(k)};
      apb(1'h1, 12'h000, 32'h1, 1'h0);
      wait_rst(60);
      `CHK(n, 60)
      {kick, ksl} <= 2'h0;
      apb(1'h1, 12'h000, 32'h0, 1'h0);
    end
    apb(1'h0, 12'h004, 32'h0, 1'h0);
    sel <= 4'h1;
    apb(1'h1, 12'h000, 32'h1, 1'h0);
    n = 0;
    for (int i = 0; i < 48; i++) begin
      @(posedge pclk);
      osc <= i[1];
      n += int'(rst === 1'b1);
    end
    `CHK(n, 0)
    osc <= 1'b0;
    apb(1'h1, 12'h000, 32'h0, 1'h0);
    $display("service test done");
    sel <= 4'h0;
    cfg <= 1'b1;
    wait_rst(40);
    `CHK(n >= BASE && n <= BASE + 6, 1'b1)
    `CHK(rc, 1'b1)
    cfg <= 1'b0;
    // The synchroniser holds the enable two more cycles, long enough for one more expiry, so that pulse falls inside the six-cycle wait.
    repeat (6) @(posedge pclk);
    `CHK(rc, 1'b0)
    wait_rst(40);
    `CHK(n, 40)
    $display("config test done");
    wrap_up();
  end
  // Whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    wrap_up();
  end
endmodule // wdps_top_test
`default_nettype wire
